// ==== src/mgmt_defines.vh ====
// constants for the station management slave and its reset sequencing
// assumes a 25 MHz system clock
`ifndef MGMT_DEFINES_VH
`define MGMT_DEFINES_VH
`define CLK_MHZ 25
`define HW_RST_RELEASE_US 2000
`define HW_RST_RELEASE_CYC (`HW_RST_RELEASE_US * `CLK_MHZ)
`define SW_RST_CYC 16
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define REG_CTRL 5'h00
`define REG_STAT 5'h01
`define CTRL_RST_BIT 15
`define STAT_NOPRE_BIT 6
`define CTRL_DEFAULT 16'h3000
`define STAT_DEFAULT 16'h7849
`define ID1_DEFAULT 16'h0180
`define ID2_DEFAULT 16'h0000
`define ADV_DEFAULT 16'h01e1
`define SPEC2_DEFAULT 16'h2080
`define STRAP_ALL_ZERO 3'h7
`define STRAP_BASE_4 5'h06
`define STRAP_BASE_5 5'h0c
`define STRAP_BASE_6 5'h12
`endif

// ==== src/port_regs.v ====
// one port's register set with its own software reset
// assumes writes come as one-cycle strobes on the system clock
`timescale 1ns/1ps
`include "mgmt_defines.vh"
module port_regs #(
  parameter SW_RST_CYC = `SW_RST_CYC
) (
  input wire i_clk,
  input wire i_nrst,
  input wire i_hw_busy,
  input wire i_wr,
  input wire [4:0] i_reg,
  input wire [15:0] i_wdata,
  output reg [15:0] o_rdata
);
  // ==========================================================
  // register storage
  reg [15:0] regs [0:31];
  reg [7:0] sw_cnt;
  wire sw_busy = (sw_cnt != 8'h00);
  integer k;

  function [15:0] dflt;
    input [4:0] a;
    begin
      case (a)
        5'h00: dflt = `CTRL_DEFAULT;
        5'h01: dflt = `STAT_DEFAULT;
        5'h02: dflt = `ID1_DEFAULT;
        5'h03: dflt = `ID2_DEFAULT; // identity value arbitrary
        5'h04: dflt = `ADV_DEFAULT;
        5'h1d: dflt = `SPEC2_DEFAULT;
        default: dflt = 16'h0000;
      endcase
    end
  endfunction

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sw_cnt <= 8'h00;
      for (k = 0; k < 32; k = k + 1) regs[k] <= 16'h0000;
    end else if (i_hw_busy) begin
      sw_cnt <= 8'h00;
      for (k = 0; k < 32; k = k + 1) regs[k] <= dflt(k[4:0]); // (R18)
    end else if (sw_busy) begin
      sw_cnt <= sw_cnt - 8'h01;
      for (k = 0; k < 32; k = k + 1) regs[k] <= dflt(k[4:0]); // (R19)
    end else if (i_wr) begin
      if (i_reg == `REG_CTRL && i_wdata[`CTRL_RST_BIT])
        sw_cnt <= SW_RST_CYC[7:0]; // (R17)
      else if (i_reg != `REG_STAT)
        regs[i_reg] <= i_wdata;
    end
  end

  always @* begin
    o_rdata = regs[i_reg];
    if (i_reg == `REG_STAT) o_rdata[`STAT_NOPRE_BIT] = 1'b1; // (R3)
    if (i_reg == `REG_CTRL && sw_busy) o_rdata[`CTRL_RST_BIT] = 1'b1; // (R17)
  end
endmodule // port_regs

// ==== src/mgmt_slave.v ====
// station management slave: serial frame decode, eight ports, reset sequencing
// assumes management clock and data pins arrive asynchronously to I_MCLK
// Summary of operation
// (R1) management clock from the entity stays at or below 12.5 MHz
// (R2) frame order: preamble, start, opcode, port, register, turnaround, data, idle
// (R3) frames without preamble accepted; status bit 6 reads one
// (R4) start pattern 01 marks the frame boundary
// (R5) opcode 10 reads, 01 writes
// (R6) port address five bits, msb first
// (R7) each port's address comes from straps caught at hardware reset
// (R8) register address five bits, msb first
// (R9) entity drives 10 during write turnaround
// (R10) read turnaround: first bit undriven, second bit driven low
// (R11) sixteen data bits, bit 15 first
// (R12) data line released in idle
// (R13) entity never pauses or aborts a frame
// (R14) reset input held low at least 1 ms
// (R15) no internal power-up reset; external pulse required
// (R16) normal operation starts 2 ms after reset release
// (R17) control bit 15 starts self-clearing software reset, reads one while busy
// (R18) hardware reset samples straps and defaults all ports
// (R19) software reset defaults only its port, straps not resampled
// (R20) strap pins sampled during reset, become outputs afterwards
// (R21) strap code selects base address table; 111 puts all ports at zero; code answers address zero from port 0 only
// (R22) unmatched port address ignored, line left undriven
// (R23) write applied only after all sixteen data bits
`timescale 1ns/1ps
`include "mgmt_defines.vh"
module mgmt_slave #(
  parameter RELEASE_CYC = `HW_RST_RELEASE_CYC,
  parameter NPORTS = 8
) (
  input wire I_MCLK,
  input wire I_NRST,
  input wire I_MDC,
  input wire I_MDIO,
  output reg O_MDIO,
  output reg O_MDIO_OE,
  input wire [2:0] I_STRAP,
  input wire [2:0] I_STRAP_OUT_VAL,
  output reg [2:0] O_STRAP_OUT,
  output reg O_STRAP_OE,
  output wire O_READY
);
  // ==========================================================
  // pin synchronisers; the first stage feeds only the second
  reg mdc_s1, mdc_s2, mdc_d;
  reg mdio_s1, mdio_s2;
  reg [2:0] strap_s1, strap_s2;
  always @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      mdc_s1 <= 1'b0;
      mdc_s2 <= 1'b0;
      mdc_d <= 1'b0;
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
    end else begin
      mdc_s1 <= I_MDC;
      mdc_s2 <= mdc_s1;
      mdc_d <= mdc_s2;
      mdio_s1 <= I_MDIO;
      mdio_s2 <= mdio_s1;
      strap_s1 <= I_STRAP;
      strap_s2 <= strap_s1;
    end
  end
  wire rise = mdc_s2 & ~mdc_d;
  wire fall = ~mdc_s2 & mdc_d;

  // ==========================================================
  // hardware reset release timer and strap capture
  // no power-up reset exists: everything waits on I_NRST (R15)
  reg [31:0] rel_cnt;
  reg [2:0] strap;
  wire hw_busy = (rel_cnt != 32'h0);
  assign O_READY = ~hw_busy;
  always @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rel_cnt <= RELEASE_CYC; // (R16)
      strap <= 3'h0;
      O_STRAP_OE <= 1'b0;
      O_STRAP_OUT <= 3'h0;
    end else begin
      O_STRAP_OUT <= I_STRAP_OUT_VAL;
      if (hw_busy) begin
        rel_cnt <= rel_cnt - 32'h1; // (R16)
        strap <= strap_s2; // (R7) (R18) (R20)
        O_STRAP_OE <= 1'b0;
      end else begin
        O_STRAP_OE <= 1'b1; // (R20)
      end
    end
  end

  // ==========================================================
  // port address decode from straps
  reg [4:0] base;
  always @* begin
    case (strap) // (R21)
      3'h4: base = `STRAP_BASE_4;
      3'h5: base = `STRAP_BASE_5;
      3'h6: base = `STRAP_BASE_6;
      default: base = {strap[1:0], 3'h0};
    endcase
  end

  // ==========================================================
  // frame state machine, one step per sampled rising edge
  localparam S_IDLE = 6'h01;
  localparam S_ST = 6'h02;
  localparam S_HDR = 6'h04;
  localparam S_TA = 6'h08;
  localparam S_DATA = 6'h10;
  localparam S_SKIP = 6'h20;
  reg [5:0] state;
  reg [4:0] cnt;
  reg [13:0] hdr;
  reg [15:0] sh;
  reg rd;
  reg hit;
  reg [2:0] port;
  reg wr_pulse;
  reg [15:0] wdata;
  wire [1:0] op = hdr[11:10];
  wire [4:0] padr = hdr[9:5];
  wire [4:0] radr = hdr[4:0];
  reg match;
  reg [2:0] mport;
  integer p;
  always @* begin
    match = 1'b0;
    mport = 3'h0;
    for (p = NPORTS - 1; p >= 0; p = p - 1) begin
      if (strap == `STRAP_ALL_ZERO) begin
        if (padr == 5'h00) begin
          match = 1'b1;
          mport = 3'h0;
        end
      end else if (padr == base + p[4:0]) begin // (R7) (R6)
        match = 1'b1;
        mport = p[2:0];
      end
    end
  end

  wire [15:0] rdata [0:NPORTS-1];
  genvar g;
  generate
    for (g = 0; g < NPORTS; g = g + 1) begin : gen_port
      port_regs u_regs (
        .i_clk(I_MCLK),
        .i_nrst(I_NRST),
        .i_hw_busy(hw_busy),
        .i_wr(wr_pulse && port == g),
        .i_reg(radr),
        .i_wdata(wdata),
        .o_rdata(rdata[g])
      );
    end
  endgenerate

  always @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state <= S_IDLE;
      cnt <= 5'h0;
      hdr <= 14'h0;
      sh <= 16'h0;
      rd <= 1'b0;
      hit <= 1'b0;
      port <= 3'h0;
      wr_pulse <= 1'b0;
      wdata <= 16'h0;
    end else begin
      wr_pulse <= 1'b0;
      if (hw_busy) begin
        state <= S_IDLE;
      end else if (rise) begin
        case (state)
          S_IDLE: begin
            // preamble optional: any zero is the start bit (R3) (R4)
            if (!mdio_s2) state <= S_ST;
          end
          S_ST: begin
            cnt <= 5'h0;
            state <= mdio_s2 ? S_HDR : S_IDLE; // (R4) (R2)
          end
          S_HDR: begin
            hdr <= {hdr[12:0], mdio_s2}; // (R6) (R8)
            cnt <= cnt + 5'h1;
            if (cnt == 5'd11) begin
              state <= S_TA;
              cnt <= 5'h0;
            end
          end
          S_TA: begin
            cnt <= cnt + 5'h1;
            if (cnt == 5'h0) begin
              rd <= (op == `OP_READ); // (R5)
              hit <= match && (op == `OP_READ || op == `OP_WRITE); // (R22)
              port <= mport;
              sh <= rdata[mport];
            end else begin
              state <= S_DATA;
              cnt <= 5'h0;
            end
          end
          S_DATA: begin
            cnt <= cnt + 5'h1;
            if (rd) sh <= {sh[14:0], 1'b0}; // (R11)
            else sh <= {sh[14:0], mdio_s2}; // (R11)
            if (cnt == 5'd15) begin
              state <= S_IDLE;
              if (!rd && hit) begin
                wdata <= {sh[14:0], mdio_s2};
                wr_pulse <= 1'b1; // (R23)
              end
            end
          end
          S_SKIP: state <= S_IDLE;
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // line driver, updated on falling edges so data is stable at rise
  always @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_MDIO <= 1'b1;
      O_MDIO_OE <= 1'b0;
    end else if (hw_busy) begin
      O_MDIO_OE <= 1'b0;
    end else if (fall) begin
      if (state == S_TA && cnt == 5'h1 && rd && hit) begin
        O_MDIO <= 1'b0; // (R10)
        O_MDIO_OE <= 1'b1;
      end else if (state == S_DATA && rd && hit) begin
        O_MDIO <= sh[15]; // (R11)
        O_MDIO_OE <= 1'b1;
      end else begin
        O_MDIO <= 1'b1;
        O_MDIO_OE <= 1'b0; // (R12) (R22) (R10)
      end
    end
  end
endmodule // mgmt_slave

// ==== verif/mdio_station.sv ====
// management entity model driving mdc and the data line
// assumes clk is the 25 MHz clock; pull-up resolved by the bench
`timescale 1ns/1ps
`include "mgmt_defines.vh"
module mdio_station (
  input wire clk,
  input wire mdi,
  input wire dev_oe,
  output reg mdc,
  output reg mdo,
  output reg moe
);
  initial begin
    mdc = 1'b0;
    mdo = 1'b1;
    moe = 1'b0;
  end
  // ==========
  // one 320 ns bit; sampled late in the high phase
  task bit_t(input b, input drv, output s, output o);
    begin
      mdo <= drv ? b : ~mdo;
      moe <= drv;
      repeat (4) @(posedge clk);
      mdc <= 1'b1;
      repeat (4) @(posedge clk);
      s = mdi;
      o = dev_oe;
      mdc <= 1'b0;
    end
  endtask
  // ==========
  // whole frame, never paused
  task frame(input [1:0] op, input [4:0] pa, input [4:0] ra, input [15:0] wd,
             input pre, output [15:0] rd, output t1, output t2, output any);
    reg [31:0] h;
    reg s, o, w;
    integer i;
    begin
      w = (op == `OP_WRITE);
      any = 1'b0;
      if (pre) for (i = 0; i < 32; i = i + 1) bit_t(1'b1, 1'b1, s, o);
      h = {2'h1, op, pa, ra, 2'h2, wd};
      for (i = 31; i >= 0; i = i - 1) begin
        bit_t(h[i], w || i > 17, s, o);
        if (i == 17) t1 = o;
        if (i == 16) t2 = s;
        if (i < 16) rd[i] = s;
        any = any | o;
      end
      moe <= 1'b0;
      mdo <= ~mdo;
      repeat (8) @(posedge clk);
    end
  endtask
endmodule // mdio_station

// ==== verif/mgmt_slave_properties.sv ====
// timing checks on the management slave ports
// assumes binding into mgmt_slave
`timescale 1ns/1ps
module mgmt_slave_props #(
  parameter RELEASE_CYC = 50000
) (
  input wire I_MCLK,
  input wire I_NRST,
  input wire I_MDC,
  input wire O_MDIO,
  input wire O_MDIO_OE,
  input wire [2:0] I_STRAP_OUT_VAL,
  input wire [2:0] O_STRAP_OUT,
  input wire O_STRAP_OE,
  input wire O_READY
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_NRST);
  // ==========
  // counters: cycles since release, mdc rises while driving
  reg [31:0] cnt;
  reg [4:0] rises;
  reg mdc_q;
  always @(posedge I_MCLK or negedge I_NRST) begin
    if (!I_NRST) begin
      cnt <= 32'h0;
      rises <= 5'h0;
      mdc_q <= 1'b0;
    end else begin
      if (cnt <= RELEASE_CYC) cnt <= cnt + 32'h1;
      mdc_q <= I_MDC;
      if (!O_MDIO_OE) rises <= 5'h0;
      else if (I_MDC && !mdc_q) rises <= rises + 5'h1;
    end
  end
  // ==========
  a_ready_early: assert property (cnt < RELEASE_CYC |-> !O_READY) else $error("ready early");
  a_ready_late: assert property (cnt > RELEASE_CYC |-> O_READY) else $error("ready late");
  a_ready_quiet: assert property (!O_READY |-> !O_MDIO_OE) else $error("drive in reset");
  a_strap_hidden: assert property (!O_READY |-> !O_STRAP_OE) else $error("strap oe");
  a_strap_rise: assert property ($rose(O_READY) |-> ##[0:2] O_STRAP_OE) else $error("strap off");
  a_strap_copy: assert property (O_STRAP_OE && $past(O_STRAP_OE)
    |-> O_STRAP_OUT == $past(I_STRAP_OUT_VAL)) else $error("strap value");
  a_ta_zero: assert property ($rose(O_MDIO_OE) |-> !O_MDIO) else $error("ta not 0");
  a_read_length: assert property ($fell(O_MDIO_OE) |-> rises == 5'd17) else $error("length");
  a_data_stable: assert property (I_MDC && $past(I_MDC) && O_MDIO_OE && $past(O_MDIO_OE)
    |-> $stable(O_MDIO)) else $error("data moved");
endmodule // mgmt_slave_props
bind mgmt_slave mgmt_slave_props #(.RELEASE_CYC(RELEASE_CYC)) i_mgmt_slave_props (
  .I_MCLK(I_MCLK), .I_NRST(I_NRST), .I_MDC(I_MDC), .O_MDIO(O_MDIO), .O_MDIO_OE(O_MDIO_OE),
  .I_STRAP_OUT_VAL(I_STRAP_OUT_VAL), .O_STRAP_OUT(O_STRAP_OUT), .O_STRAP_OE(O_STRAP_OE),
  .O_READY(O_READY));

// ==== verif/mgmt_slave_tb.sv ====
// self-checking bench for the management slave
// assumes the entity model in mdio_station
`timescale 1ns/1ps
`include "mgmt_defines.vh"
module mgmt_slave_tb;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [2:0] strap = 3'h0;
  reg [2:0] sval = 3'h5;
  wire mdc, mdo, moe, dm, doe, soe, ready;
  wire [2:0] sout;
  wire line = doe ? dm : (moe ? mdo : 1'b1);
  integer n_fail = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  reg [15:0] rd;
  reg t1, t2, any;
  always #20 clk = ~clk;
  // short release count keeps the run brief
  mgmt_slave #(.RELEASE_CYC(20)) i_mgmt_slave (.I_MCLK(clk), .I_NRST(nrst), .I_MDC(mdc),
    .I_MDIO(line), .O_MDIO(dm), .O_MDIO_OE(doe), .I_STRAP(strap), .I_STRAP_OUT_VAL(sval),
    .O_STRAP_OUT(sout), .O_STRAP_OE(soe), .O_READY(ready));
  mdio_station i_mdio_station (.clk(clk), .mdi(line), .dev_oe(doe), .mdc(mdc), .mdo(mdo),
    .moe(moe));
  // ==========
  task chk16(input [15:0] v, input [15:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (v !== e) begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, v, e);
      end
    end
  endtask
  task chk1(input v, input e);
    chk16({15'h0, v}, {15'h0, e});
  endtask
  function [4:0] adr(input [2:0] c, input [2:0] p);
    adr = c == 3'h7 ? 5'h0 : (c[2] ? 5'h6 * ({3'h0, c[1:0]} + 5'h1) : {c[1:0], 3'h0}) + p;
  endfunction
  task rdf(input [4:0] pa, input [4:0] ra, input pre);
    i_mdio_station.frame(`OP_READ, pa, ra, 16'h0, pre, rd, t1, t2, any);
  endtask
  task wrf(input [4:0] pa, input [4:0] ra, input [15:0] wd);
    i_mdio_station.frame(`OP_WRITE, pa, ra, wd, 1'b0, rd, t1, t2, any);
  endtask
  task hw_reset(input [2:0] code);
    integer i;
    begin
      nrst <= 1'b0;
      strap <= code;
      sval <= code ^ 3'h5;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      for (i = 0; i < 100 && ready !== 1'b1; i = i + 1) @(posedge clk);
      @(posedge clk);
      strap <= ~code; // pins now in output duty
      // registered outputs settle after the edge; look at them mid-cycle
      @(negedge clk);
      chk1(soe, 1'b1);
      chk16({13'h0, sout}, {13'h0, sval});
    end
  endtask
  // ==========
  task s_map;
    integer c, p;
    begin
      for (c = 0; c < 8; c = c + 1) begin
        hw_reset(c[2:0]);
        for (p = 0; p < 8; p = p + 1) begin
          rdf(adr(c[2:0], p[2:0]), `REG_CTRL, p[0]);
          chk16(rd, `CTRL_DEFAULT);
          chk1(t1, 1'b0);
          chk1(t2, 1'b0);
        end
        rdf(adr(c[2:0], 3'h7) + 5'h1, `REG_CTRL, 1'b0);
        chk1(any, 1'b0);
        chk16(rd, 16'hffff);
      end
    end
  endtask
  task s_regs;
    integer p;
    begin
      hw_reset(3'h1);
      for (p = 0; p < 8; p = p + 1) wrf(5'h8 + p[4:0], 5'h4, 16'h0a50 + p[15:0]);
      for (p = 0; p < 8; p = p + 1) begin
        rdf(5'h8 + p[4:0], 5'h4, 1'b1);
        chk16(rd, 16'h0a50 + p[15:0]);
      end
      wrf(5'h9, `REG_STAT, 16'h0000);
      rdf(5'h9, `REG_STAT, 1'b0);
      chk16(rd, `STAT_DEFAULT);
      chk1(rd[`STAT_NOPRE_BIT], 1'b1);
      wrf(5'ha, `REG_CTRL, 16'h8000);
      rdf(5'ha, `REG_CTRL, 1'b0);
      chk16(rd, `CTRL_DEFAULT);
      rdf(5'ha, 5'h4, 1'b0);
      chk16(rd, `ADV_DEFAULT);
      rdf(5'hb, 5'h4, 1'b0);
      chk16(rd, 16'h0a53);
      hw_reset(3'h1);
      rdf(5'hb, 5'h4, 1'b0);
      chk16(rd, `ADV_DEFAULT);
    end
  endtask
  // ==========
  task close_out;
    begin
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      close_out;
    end
  end
  initial begin
    s_map;
    s_regs;
    close_out;
  end
endmodule // mgmt_slave_tb
